// ==== cbt_can_node.sv ====
// partner: other can nodes as seen from the controller's bus side
`timescale 1ns/1ps
`default_nettype none
module cbt_can_node (
	input  wire logic aclk,
	output var  logic can_rx,
	output var  logic bus_activity,
	output var  logic idle_seq_done
);
	// the bus idles recessive through its pull-up
	initial begin
		can_rx = 1'b1;
		bus_activity = 1'b0;
		idle_seq_done = 1'b0;
	end
	// drive a level for n cycles, then release to recessive
	task automatic level(input logic v, input int n);
		@(posedge aclk);
		can_rx <= v;
		repeat (n) @(posedge aclk);
		can_rx <= 1'b1;
	endtask
	// eleven recessive bits close each idle sequence
	task automatic idle(input int n);
		repeat (n) begin
			repeat (10) @(posedge aclk);
			idle_seq_done <= 1'b1;
			@(posedge aclk);
			idle_seq_done <= 1'b0;
		end
	endtask
	// short dominant burst seen as bus activity
	task automatic wake();
		@(posedge aclk);
		bus_activity <= 1'b1;
		@(posedge aclk);
		bus_activity <= 1'b0;
	endtask
endmodule // cbt_can_node
`default_nettype wire

// ==== cbt_core.sv ====
// module: can bit timing, sampling and receiver flag logic with axi4-lite
//
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module cbt_core (
	input  wire logic                aclk,
	input  wire logic                aresetn,
	input  wire logic [7:0]          s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output var  logic                s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output var  logic                s_axi_wready,
	output var  logic [1:0]          s_axi_bresp,
	output var  logic                s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [7:0]          s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output var  logic                s_axi_arready,
	output var  logic [31:0]         s_axi_rdata,
	output var  logic [1:0]          s_axi_rresp,
	output var  logic                s_axi_rvalid,
	input  wire logic                s_axi_rready,
	input  wire logic                can_rx,
	input  wire logic [7:0]          rx_error_count,
	input  wire logic [8:0]          tx_error_count,
	input  wire logic                sleep_mode,
	input  wire logic                bus_activity,
	input  wire logic                overrun_event,
	input  wire logic                rx_msg_done,
	input  wire logic                idle_seq_done,
	input  wire logic                edge_resync,
	input  wire logic [3:0]          phase_err,
	input  wire logic                phase_late,
	output var  logic                tq_tick,
	output var  logic                sample_point,
	output var  logic                rx_bit,
	output var  logic                bit_start,
	output var  logic                buffer_swap,
	output var  logic                abort_transfer,
	output var  logic                soft_reset_active,
	output var  logic                timing_invalid,
	output var  logic                irq_wakeup,
	output var  logic                irq_error,
	output var  logic                irq_receive
);
	import cbt_pkg::*;

	// ------------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic       aw_q, w_q, bv_q, rv_q, awr_q, wr_q, arr_q;
		logic [7:0] awa_q;
		logic [7:0] wd_q;
		logic       wbe_q;
		logic [1:0] br_q, rr_q;
		logic [31:0] rd_q;
		logic [7:0] ctrl_q, cfga_q, cfgb_q, flag_q, ien_q;
		logic [5:0] pre_q;
		logic [4:0] tq_q;
		cbt_phase_e ph_q;
		logic [2:0] smp_q;
		logic       tick_q, sp_q, bit_q, bs_q, swap_q, abort_q, inv_q;
		logic [7:0] idle_q;
		logic       iw_q, ie_q, ir_q;
	} cbt_state_s;

	cbt_state_s s_q, s_d;

	function automatic logic [7:0] cbt_rd(input cbt_state_s s, input logic [7:0] a);
		if (a == CBT_ADDR_CONTROL) cbt_rd = s.ctrl_q;
		else if (a == CBT_ADDR_CFG_A) cbt_rd = s.cfga_q;
		else if (a == CBT_ADDR_CFG_B) cbt_rd = s.cfgb_q;
		else if (a == CBT_ADDR_FLAGS) cbt_rd = s.flag_q;
		else if (a == CBT_ADDR_ENABLES) cbt_rd = s.ien_q;
		else if (a == CBT_ADDR_TIMING) cbt_rd = {s.inv_q, 2'h0, s.tq_q};
		else cbt_rd = 8'h00;
	endfunction

	function automatic logic cbt_mapped(input logic [7:0] a);
		cbt_mapped = (a <= CBT_ADDR_TIMING) && (a[1:0] == 2'h0);
	endfunction

	logic       srst;
	logic       wr_go;
	logic [7:0] set_v, clr_v, cond_v;
	logic [4:0] seg1_len, seg2_len;
	logic [2:0] seg2_max;
	logic       vote;
	logic       tq_go;
	logic [4:0] jlim;
	logic [3:0] jump;

	always_comb begin
		s_d = s_q;
		srst = s_q.ctrl_q[CBT_SOFT_RESET_BIT];
		// --------------------------------------------------------------------
		// axi4-lite slave: one write and one read in flight
		// --------------------------------------------------------------------
		s_d.awr_q = 1'b0;
		s_d.wr_q = 1'b0;
		s_d.arr_q = 1'b0;
		if (!s_q.aw_q && !s_q.bv_q && s_axi_awvalid && !s_q.awr_q) begin
			s_d.awr_q = 1'b1;
			s_d.aw_q = 1'b1;
			s_d.awa_q = s_axi_awaddr;
		end
		if (!s_q.w_q && !s_q.bv_q && s_axi_wvalid && !s_q.wr_q) begin
			s_d.wr_q = 1'b1;
			s_d.w_q = 1'b1;
			s_d.wd_q = s_axi_wdata[7:0];
			s_d.wbe_q = s_axi_wstrb[0];
		end
		wr_go = s_q.aw_q && s_q.w_q && !s_q.bv_q;
		clr_v = 8'h00;
		if (wr_go) begin
			s_d.aw_q = 1'b0;
			s_d.w_q = 1'b0;
			s_d.bv_q = 1'b1;
			s_d.br_q = cbt_mapped(s_q.awa_q) ? CBT_AXI_OKAY : CBT_AXI_SLVERR;
			if (s_q.wbe_q) begin
				if (s_q.awa_q == CBT_ADDR_CONTROL)
					s_d.ctrl_q = s_q.wd_q & CBT_CTRL_RESET;
				else if (s_q.awa_q == CBT_ADDR_CFG_A && srst)
					s_d.cfga_q = s_q.wd_q;
				else if (s_q.awa_q == CBT_ADDR_CFG_B && srst)
					s_d.cfgb_q = s_q.wd_q;
				else if (s_q.awa_q == CBT_ADDR_FLAGS)
					clr_v = s_q.wd_q;
				else if (s_q.awa_q == CBT_ADDR_ENABLES)
					s_d.ien_q = s_q.wd_q;
			end
		end
		if (s_q.bv_q && s_axi_bready)
			s_d.bv_q = 1'b0;
		if (!s_q.rv_q && s_axi_arvalid && !s_q.arr_q) begin
			s_d.arr_q = 1'b1;
			s_d.rv_q = 1'b1;
			s_d.rd_q = {24'h0, cbt_rd(s_q, s_axi_araddr)};
			s_d.rr_q = cbt_mapped(s_axi_araddr) ? CBT_AXI_OKAY : CBT_AXI_SLVERR;
		end else if (s_q.rv_q && s_axi_rready)
			s_d.rv_q = 1'b0;
		// --------------------------------------------------------------------
		// time quantum and bit timing
		// --------------------------------------------------------------------
		seg1_len = {1'b0, s_q.cfgb_q[3:0]} + 5'h01;
		seg2_max = s_q.cfgb_q[6:CBT_SEG2_LSB];
		seg2_len = {2'b0, seg2_max} + 5'h01;
		s_d.inv_q = (s_q.cfgb_q[3:0] < CBT_SEG1_MIN)
			|| (seg2_max < CBT_SEG2_MIN);
		tq_go = !srst && (s_q.pre_q == s_q.cfga_q[5:0]);
		// phase error is clipped here so a bad caller cannot break timing
		jlim = {3'b0, s_q.cfga_q[CBT_JUMP_LSB +: 2]} + 5'h01;
		jump = ({1'b0, phase_err} > jlim) ? jlim[3:0] : phase_err;
		s_d.tick_q = 1'b0;
		s_d.sp_q = 1'b0;
		s_d.bs_q = 1'b0;
		if (srst) begin
			s_d.pre_q = 6'h00;
			s_d.tq_q = 5'h00;
			s_d.ph_q = CBT_PH_SYNC;
		end else if (s_q.pre_q == s_q.cfga_q[5:0]) begin
			s_d.pre_q = 6'h00;
			s_d.tick_q = 1'b1;
			s_d.smp_q = {s_q.smp_q[1:0], can_rx};
			s_d.tq_q = s_q.tq_q + 5'h01;
			// bit time is prescale * (1 + seg1 + seg2) clocks
			case (s_q.ph_q)
				CBT_PH_SYNC: begin
					s_d.ph_q = CBT_PH_SEG1;
					s_d.tq_q = 5'h00;
				end
				CBT_PH_SEG1: begin
					if (edge_resync && phase_late && s_q.tq_q == 5'h00)
						s_d.tq_q = 5'h00 - {1'b0, jump};
					if (s_q.tq_q + 5'h01 == seg1_len) begin
						s_d.ph_q = CBT_PH_SEG2;
						s_d.tq_q = 5'h00;
						s_d.sp_q = 1'b1;
					end
				end
				CBT_PH_SEG2: begin
					if ((s_q.tq_q + 5'h01 == seg2_len) || (edge_resync && !phase_late
						&& s_q.tq_q + 5'h01 + {1'b0, jump} >= seg2_len)) begin
						s_d.ph_q = CBT_PH_SYNC;
						s_d.bs_q = 1'b1;
					end
				end
				default: s_d.ph_q = CBT_PH_SYNC;
			endcase
		end else
			s_d.pre_q = s_q.pre_q + 6'h01;
		vote = (s_q.smp_q[0] & s_q.smp_q[1]) | (s_q.smp_q[1] & can_rx)
			| (s_q.smp_q[0] & can_rx);
		if (s_d.sp_q)
			s_d.bit_q = s_q.cfgb_q[CBT_MAJ_BIT] ? vote : can_rx;
		// --------------------------------------------------------------------
		// receiver flags
		// --------------------------------------------------------------------
		cond_v = 8'h00;
		cond_v[CBT_FLAG_WAKE] = sleep_mode && bus_activity;
		cond_v[CBT_FLAG_RXWARN] = ({1'b0, rx_error_count} > CBT_WARN_LIMIT)
			&& !(s_q.flag_q[CBT_FLAG_RXPASS] || s_q.flag_q[CBT_FLAG_TXPASS]
			|| s_q.flag_q[CBT_FLAG_BUSOFF]);
		cond_v[CBT_FLAG_TXWARN] = (tx_error_count > CBT_WARN_LIMIT)
			&& !(s_q.flag_q[CBT_FLAG_RXPASS] || s_q.flag_q[CBT_FLAG_TXPASS]
			|| s_q.flag_q[CBT_FLAG_BUSOFF]);
		cond_v[CBT_FLAG_RXPASS] = ({1'b0, rx_error_count} > CBT_PASS_LIMIT)
			&& !s_q.flag_q[CBT_FLAG_BUSOFF];
		cond_v[CBT_FLAG_TXPASS] = (tx_error_count > CBT_PASS_LIMIT)
			&& !s_q.flag_q[CBT_FLAG_BUSOFF];
		cond_v[CBT_FLAG_BUSOFF] = (tx_error_count > CBT_BOFF_LIMIT);
		cond_v[CBT_FLAG_OVR] = overrun_event;
		cond_v[CBT_FLAG_FULL] = rx_msg_done && !s_q.flag_q[CBT_FLAG_FULL];
		set_v = cond_v;
		// bus-off held until enough idle sequences seen
		if (s_q.idle_q != CBT_IDLE_SEQS)
			set_v[CBT_FLAG_BUSOFF] = set_v[CBT_FLAG_BUSOFF]
				| s_q.flag_q[CBT_FLAG_BUSOFF];
		if (cond_v[CBT_FLAG_BUSOFF] || !s_q.flag_q[CBT_FLAG_BUSOFF])
			s_d.idle_q = 8'h00;
		else if (idle_seq_done && s_q.idle_q != CBT_IDLE_SEQS)
			s_d.idle_q = s_q.idle_q + 8'h01;
		// set wins over clear; clear blocked while condition remains
		s_d.flag_q = (s_q.flag_q & ~(clr_v & ~cond_v)) | set_v;
		s_d.swap_q = cond_v[CBT_FLAG_FULL];
		if (srst) begin
			s_d.flag_q = CBT_FLAG_RESET;
			s_d.ien_q = CBT_FLAG_RESET;
			s_d.swap_q = 1'b0;
		end
		s_d.abort_q = srst;
		s_d.iw_q = s_d.flag_q[CBT_FLAG_WAKE] && s_d.ien_q[CBT_FLAG_WAKE];
		s_d.ie_q = |(s_d.flag_q & s_d.ien_q & CBT_ERR_MASK);
		s_d.ir_q = s_d.flag_q[CBT_FLAG_FULL] && s_d.ien_q[CBT_FLAG_FULL];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
			s_q.ctrl_q <= CBT_CTRL_RESET;
			s_q.cfga_q <= CBT_CFG_RESET;
			s_q.cfgb_q <= CBT_CFG_RESET;
			s_q.flag_q <= CBT_FLAG_RESET;
			s_q.smp_q <= 3'h7;
			s_q.bit_q <= 1'b1;
			s_q.ph_q <= CBT_PH_SYNC;
		end else
			s_q <= s_d;
	end

	assign s_axi_awready = s_q.awr_q;
	assign s_axi_wready = s_q.wr_q;
	assign s_axi_bvalid = s_q.bv_q;
	assign s_axi_bresp = s_q.br_q;
	assign s_axi_arready = s_q.arr_q;
	assign s_axi_rvalid = s_q.rv_q;
	assign s_axi_rdata = s_q.rd_q;
	assign s_axi_rresp = s_q.rr_q;
	assign tq_tick = s_q.tick_q;
	assign sample_point = s_q.sp_q;
	assign rx_bit = s_q.bit_q;
	assign bit_start = s_q.bs_q;
	assign buffer_swap = s_q.swap_q;
	assign abort_transfer = s_q.abort_q;
	assign soft_reset_active = s_q.ctrl_q[CBT_SOFT_RESET_BIT];
	assign timing_invalid = s_q.inv_q;
	assign irq_wakeup = s_q.iw_q;
	assign irq_error = s_q.ie_q;
	assign irq_receive = s_q.ir_q;

	// ------------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------------
	sequence cfg_write_locked;
		wr_go && s_q.wbe_q && !srst && s_q.awa_q == CBT_ADDR_CFG_A;
	endsequence
	AST_CFG_A_LOCK: assert property (@(posedge aclk) disable iff (!aresetn)
		cfg_write_locked |=> $stable(s_q.cfga_q))
		else $error("config a changed outside soft reset");
	AST_CFG_B_LOCK: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_go && !srst && s_q.awa_q == CBT_ADDR_CFG_B |=> $stable(s_q.cfgb_q))
		else $error("config b changed outside soft reset");
	AST_SOFT_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
		srst |=> s_q.flag_q == CBT_FLAG_RESET)
		else $error("flags not clear in soft reset");
	AST_PRESCALE: assert property (@(posedge aclk) disable iff (!aresetn)
		tq_tick && !srst && $stable(s_q.cfga_q) |-> s_q.pre_q == 6'h00)
		else $error("prescaler not restarted at tick");
	AST_BUSOFF_SET: assert property (@(posedge aclk) disable iff (!aresetn)
		!srst && tx_error_count > CBT_BOFF_LIMIT ##1 !srst
		|-> s_q.flag_q[CBT_FLAG_BUSOFF])
		else $error("bus-off not set");
	AST_CLEAR_BLOCK: assert property (@(posedge aclk) disable iff (!aresetn)
		!srst && overrun_event |=> s_q.flag_q[CBT_FLAG_OVR] || srst)
		else $error("overrun lost");
	AST_ERR_IRQ: assert property (@(posedge aclk) disable iff (!aresetn)
		irq_error == |(s_q.flag_q & s_q.ien_q & CBT_ERR_MASK))
		else $error("error irq mismatch");
	AST_RX_IRQ: assert property (@(posedge aclk) disable iff (!aresetn)
		irq_receive == (s_q.flag_q[CBT_FLAG_FULL] && s_q.ien_q[CBT_FLAG_FULL]))
		else $error("receive irq mismatch");
	AST_NO_SWAP: assert property (@(posedge aclk) disable iff (!aresetn)
		s_q.flag_q[CBT_FLAG_FULL] |=> !buffer_swap)
		else $error("swap while full");
	AST_ABORT: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(srst) |=> abort_transfer)
		else $error("no abort on soft reset");
	sequence seg2_tick_early;
		tq_go && s_q.ph_q == CBT_PH_SEG2 && s_q.tq_q + 5'h01 + jlim < seg2_len;
	endsequence
	AST_JUMP_LIMIT: assert property (@(posedge aclk) disable iff (!aresetn)
		seg2_tick_early |=> s_q.ph_q == CBT_PH_SEG2)
		else $error("bit shortened beyond jump limit");
	AST_SYNC_ONE: assert property (@(posedge aclk) disable iff (!aresetn)
		tq_go && s_q.ph_q == CBT_PH_SYNC |=> s_q.ph_q == CBT_PH_SEG1)
		else $error("sync segment not one quantum");
	AST_SAMPLE_SEG2: assert property (@(posedge aclk) disable iff (!aresetn)
		sample_point |-> s_q.ph_q == CBT_PH_SEG2)
		else $error("sample point outside first segment end");
	AST_ONE_SAMPLE: assert property (@(posedge aclk) disable iff (!aresetn)
		tq_go && s_q.ph_q == CBT_PH_SEG1 && s_q.tq_q + 5'h01 == seg1_len
		&& !s_q.cfgb_q[CBT_MAJ_BIT] |=> rx_bit == $past(can_rx))
		else $error("single sample mismatch");
	AST_WAKE_SET: assert property (@(posedge aclk) disable iff (!aresetn)
		!srst && sleep_mode && bus_activity |=> s_q.flag_q[CBT_FLAG_WAKE])
		else $error("wakeup flag not set");
	AST_FULL_SET: assert property (@(posedge aclk) disable iff (!aresetn)
		!srst && rx_msg_done && !s_q.flag_q[CBT_FLAG_FULL]
		|=> s_q.flag_q[CBT_FLAG_FULL] && buffer_swap)
		else $error("receive full or swap missing");
	AST_WARN_BLOCK: assert property (@(posedge aclk) disable iff (!aresetn)
		s_q.flag_q[CBT_FLAG_RXPASS] && !s_q.flag_q[CBT_FLAG_RXWARN]
		|=> !s_q.flag_q[CBT_FLAG_RXWARN])
		else $error("rx warning set while passive");
	AST_TX_PASS: assert property (@(posedge aclk) disable iff (!aresetn)
		!srst && tx_error_count > CBT_PASS_LIMIT && !s_q.flag_q[CBT_FLAG_BUSOFF]
		|=> s_q.flag_q[CBT_FLAG_TXPASS])
		else $error("tx passive flag not set");
	AST_WAKE_IRQ: assert property (@(posedge aclk) disable iff (!aresetn)
		irq_wakeup == (s_q.flag_q[CBT_FLAG_WAKE] && s_q.ien_q[CBT_FLAG_WAKE]))
		else $error("wakeup irq mismatch");
	AST_SOFT_IEN: assert property (@(posedge aclk) disable iff (!aresetn)
		srst |=> s_q.ien_q == CBT_FLAG_RESET)
		else $error("enables not clear in soft reset");
endmodule // cbt_core
`default_nettype wire

// ==== cbt_pkg.sv ====
// package: register map, field layout and constants of the can bit timing block
// ----------------------------------------------------------------------------
// Summary of operation
// ----------------------------------------------------------------------------
// Summary of operation
// - jump width code 0..3 selects resync limit of 1..4 quanta
// - prescaler field plus one divides clock into time quantum tick
// - config a register writable only while soft reset control is set
// - majority select one takes three samples and votes, zero takes one
// - first segment is field plus one quanta; settings 0..2 invalid
// - second segment is field plus one quanta; setting of zero invalid
// - bit time is prescale over clock times quanta per bit
// - config b register writable only while soft reset control is set
// - flags clear by writing one, only after setting condition ends
// - hard or soft reset clears flags; held clear during soft reset
// - each flag with its enable asserts its interrupt request while set
// - bus activity during sleep sets wakeup flag
// - rx count above 96, no passive or bus-off flag, sets rx warning
// - tx count above 96, no passive or bus-off flag, sets tx warning
// - rx count above 127 with bus-off clear sets rx passive flag
// - tx count above 127 with bus-off clear sets tx passive flag
// - tx count above 255 sets bus-off; clearable after 128 idle sequences
// - data overrun sets overrun flag
// - good message sets rx full; while set no buffer swap; clear releases
// - soft reset aborts transfers and drops bus synchronisation at once
package cbt_pkg;
	// ------------------------------------------------------------------------
	// register byte addresses
	// ------------------------------------------------------------------------
	localparam logic [7:0] CBT_ADDR_CONTROL = 8'h00;
	localparam logic [7:0] CBT_ADDR_CFG_A   = 8'h04;
	localparam logic [7:0] CBT_ADDR_CFG_B   = 8'h08;
	localparam logic [7:0] CBT_ADDR_FLAGS   = 8'h0c;
	localparam logic [7:0] CBT_ADDR_ENABLES = 8'h10;
	localparam logic [7:0] CBT_ADDR_TIMING  = 8'h14;
	// ------------------------------------------------------------------------
	// field positions and values
	// ------------------------------------------------------------------------
	localparam int CBT_SOFT_RESET_BIT = 0;
	localparam int CBT_JUMP_LSB       = 6;
	localparam int CBT_MAJ_BIT        = 7;
	localparam int CBT_SEG2_LSB       = 4;
	localparam int CBT_FLAG_WAKE      = 7;
	localparam int CBT_FLAG_RXWARN    = 6;
	localparam int CBT_FLAG_TXWARN    = 5;
	localparam int CBT_FLAG_RXPASS    = 4;
	localparam int CBT_FLAG_TXPASS    = 3;
	localparam int CBT_FLAG_BUSOFF    = 2;
	localparam int CBT_FLAG_OVR       = 1;
	localparam int CBT_FLAG_FULL      = 0;
	localparam logic [7:0] CBT_CTRL_RESET  = 8'h01;
	localparam logic [7:0] CBT_CFG_RESET   = 8'h00;
	localparam logic [7:0] CBT_FLAG_RESET  = 8'h00;
	localparam logic [7:0] CBT_ERR_MASK    = 8'h7e;
	localparam logic [8:0] CBT_WARN_LIMIT  = 9'h060;
	localparam logic [8:0] CBT_PASS_LIMIT  = 9'h07f;
	localparam logic [8:0] CBT_BOFF_LIMIT  = 9'h0ff;
	localparam logic [7:0] CBT_IDLE_SEQS   = 8'h80;
	localparam logic [3:0] CBT_SEG1_MIN    = 4'h3;
	localparam logic [2:0] CBT_SEG2_MIN    = 3'h1;
	localparam logic [1:0] CBT_AXI_OKAY    = 2'h0;
	localparam logic [1:0] CBT_AXI_SLVERR  = 2'h2;
	// ------------------------------------------------------------------------
	// bit timing phase
	// ------------------------------------------------------------------------
	typedef enum logic [1:0] {
		CBT_PH_SYNC = 2'b00,
		CBT_PH_SEG1 = 2'b01,
		CBT_PH_SEG2 = 2'b10
	} cbt_phase_e;
endpackage

// ==== tb.sv ====
// testbench: registers, bit timing and receiver flags of the can block
`timescale 1ns/1ps
`default_nettype none
module tb;
	import cbt_pkg::*;
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00, rx_cnt = 8'h00;
	logic [31:0] wdata = 32'h0, d, rdata_w;
	logic [8:0]  tx_cnt = 9'h000;
	logic [3:0]  wstrb = 4'hf, perr = 4'h0;
	logic        rsync = 1'b0, late = 1'b0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0, sleep = 1'b0;
	logic        ovr = 1'b0, rxdone = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, can_rx;
	logic        bus_act, idle_done, tq_tick, smp, rx_bit, swap, abort, bstart;
	logic        sr_act, invalid, irq_w, irq_e, irq_r;
	logic [1:0]  bresp, rresp, r, br;
	int          bs_cnt = 0, bs_per = 0;
	int          mismatches = 0, checks = 0, mdl = 0, p = 0, swaps = 0;
	int          tq_cnt = 0, tq_per = 0, sp_cnt = 0, sp_per = 0, bc;
	logic [7:0]  seg_tab [5] = '{8'h02, 8'h03, 8'h13, 8'h10, 8'hff};

	always #25 aclk = ~aclk;

	cbt_core dut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata_w), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .can_rx(can_rx), .rx_error_count(rx_cnt),
		.tx_error_count(tx_cnt), .sleep_mode(sleep), .bus_activity(bus_act),
		.overrun_event(ovr), .rx_msg_done(rxdone),
		.idle_seq_done(idle_done), .edge_resync(rsync), .phase_err(perr),
		.phase_late(late), .tq_tick(tq_tick), .sample_point(smp),
		.rx_bit(rx_bit), .bit_start(bstart), .buffer_swap(swap),
		.abort_transfer(abort), .soft_reset_active(sr_act),
		.timing_invalid(invalid), .irq_wakeup(irq_w), .irq_error(irq_e),
		.irq_receive(irq_r)
	);
	cbt_can_node node (.aclk(aclk), .can_rx(can_rx),
		.bus_activity(bus_act), .idle_seq_done(idle_done));

	// periods between pulses, counted on the design's own clock
	always @(posedge aclk) begin
		tq_cnt <= tq_tick ? 1 : tq_cnt + 1;
		sp_cnt <= smp ? 1 : sp_cnt + 1;
		if (tq_tick === 1'b1) tq_per <= tq_cnt;
		if (smp === 1'b1) sp_per <= sp_cnt;
		bs_cnt <= bstart ? 1 : bs_cnt + 1;
		if (bstart === 1'b1) bs_per <= bs_cnt;
		if (swap === 1'b1) swaps <= swaps + 1;
	end
	// ------------------------------------------------------------------
	// bus tasks, compare and model
	// ------------------------------------------------------------------
	task automatic chk(input logic [31:0] got, exp, input string m);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		logic ah, wh, bh;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h0, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge aclk);
			ah = awready;
			wh = wready;
			bh = bvalid;
			br = bresp;
			@(posedge aclk);
			if (ah) awvalid <= 1'b0;
			if (wh) wvalid <= 1'b0;
		end while (bh !== 1'b1);
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		logic ah, rh;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge aclk);
			ah = arready;
			rh = rvalid;
			d = rdata_w;
			r = rresp;
			@(posedge aclk);
			if (ah) arvalid <= 1'b0;
		end while (rh !== 1'b1);
		rready <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, e, input string m);
		rd(a);
		chk(d, {24'h0, e}, m);
	endtask
	task automatic pulse(input bit rx);
		@(posedge aclk);
		if (rx) rxdone <= 1'b1;
		else ovr <= 1'b1;
		@(posedge aclk);
		rxdone <= 1'b0;
		ovr <= 1'b0;
		repeat (2) @(posedge aclk);
	endtask
	// flags set from the counts as seen with the old flag state
	function automatic void mdl_step(input int rc, tc);
		int f;
		f = mdl;
		if (rc > 96 && (f & 'h1c) == 0) mdl |= 'h40;
		if (tc > 96 && (f & 'h1c) == 0) mdl |= 'h20;
		if (rc > 127 && (f & 'h04) == 0) mdl |= 'h10;
		if (tc > 127 && (f & 'h04) == 0) mdl |= 'h08;
		if (tc > 255) mdl |= 'h04;
	endfunction
	task automatic counts(input int rc, tc);
		@(posedge aclk);
		rx_cnt <= rc[7:0];
		tx_cnt <= tc[8:0];
		repeat (4) @(posedge aclk);
		mdl_step(rc, tc);
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge aclk);
		mismatches++;
		test_done();
	end

	initial begin
		void'($urandom(32'h66250e9f));
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rchk(CBT_ADDR_CONTROL, CBT_CTRL_RESET, "ctrl");
		rchk(CBT_ADDR_FLAGS, CBT_FLAG_RESET, "flags");
		chk({31'h0, abort}, 32'h1, "abort");
		chk({31'h0, sr_act}, 32'h1, "srst on");
		p = $urandom % 64;
		for (int i = 0; i < 4; i++) begin
			wr(CBT_ADDR_CFG_A, 8'(i * 64 + p));
			rchk(CBT_ADDR_CFG_A, 8'(i * 64 + p), "cfga");
		end
		foreach (seg_tab[i]) begin
			wr(CBT_ADDR_CFG_B, seg_tab[i]);
			repeat (2) @(negedge aclk);
			chk({31'h0, invalid}, 32'(seg_tab[i][3:0] < 3 ||
				seg_tab[i][6:4] < 1), "invalid");
		end
		// majority with a six quanta first segment keeps phase one >= 2
		wr(CBT_ADDR_CFG_B, 8'ha5);
		wr(CBT_ADDR_CONTROL, 8'h00);
		chk({31'h0, sr_act}, 32'h0, "srst off");
		wr(CBT_ADDR_CFG_A, 8'(~p));
		chk({30'h0, br}, {30'h0, CBT_AXI_OKAY}, "locked resp");
		rchk(CBT_ADDR_CFG_A, 8'(192 + p), "cfga lock");
		wr(CBT_ADDR_CFG_B, 8'h13);
		rchk(CBT_ADDR_CFG_B, 8'ha5, "cfgb lock");
		bc = 10 * (p + 1);
		repeat (3 * bc) @(posedge aclk);
		chk(tq_per, p + 1, "tq period");
		chk(sp_per, bc, "bit period");
		chk(bs_per, bc, "bit start");
		fork
			node.level(1'b0, 3 * bc);
			begin
				repeat (5 * bc / 2) @(negedge aclk);
				chk({31'h0, rx_bit}, 32'h0, "dominant");
			end
		join
		repeat (3 * bc) @(negedge aclk);
		chk({31'h0, rx_bit}, 32'h1, "recessive");
		// jump limit of one quantum caps the early end of segment two
		wr(CBT_ADDR_CONTROL, 8'h01);
		wr(CBT_ADDR_CFG_A, 8'(p));
		wr(CBT_ADDR_CFG_B, 8'h73);
		wr(CBT_ADDR_CONTROL, 8'h00);
		rsync <= 1'b1;
		perr <= 4'($urandom % 14 + 2);
		repeat (36 * (p + 1)) @(posedge aclk);
		chk(sp_per, 12 * (p + 1), "jump limit");
		rsync <= 1'b0;
		wr(CBT_ADDR_ENABLES, 8'hff);
		wstrb <= 4'h0;
		wr(CBT_ADDR_ENABLES, 8'h00);
		wstrb <= 4'hf;
		rchk(CBT_ADDR_ENABLES, 8'hff, "strobe");
		repeat (6) begin
			counts($urandom % 256, $urandom % 256);
			rchk(CBT_ADDR_FLAGS, 8'(mdl), "flags");
			chk({31'h0, irq_e}, 32'((mdl & 'h7e) != 0), "irq");
			counts(0, 0);
			wr(CBT_ADDR_FLAGS, 8'hff);
			mdl = 0;
			rchk(CBT_ADDR_FLAGS, 8'h00, "clear");
		end
		counts(100, 0);
		wr(CBT_ADDR_FLAGS, 8'hff);
		rchk(CBT_ADDR_FLAGS, 8'h40, "held");
		counts(0, 256);
		rchk(CBT_ADDR_FLAGS, 8'(mdl), "bus off");
		counts(0, 0);
		wr(CBT_ADDR_FLAGS, 8'hff);
		rchk(CBT_ADDR_FLAGS, 8'h04, "bus off held");
		node.idle(127);
		wr(CBT_ADDR_FLAGS, 8'hff);
		rchk(CBT_ADDR_FLAGS, 8'h04, "127 idle");
		node.idle(1);
		wr(CBT_ADDR_FLAGS, 8'hff);
		rchk(CBT_ADDR_FLAGS, 8'h00, "128 idle");
		pulse(0);
		rchk(CBT_ADDR_FLAGS, 8'h02, "overrun");
		chk({31'h0, irq_e}, 32'h1, "ovr irq");
		wr(CBT_ADDR_FLAGS, 8'h02);
		pulse(1);
		// buffer contents are only valid once rx full is seen
		rchk(CBT_ADDR_FLAGS, 8'h01, "rx full");
		chk({31'h0, irq_r}, 32'h1, "rx irq");
		pulse(1);
		chk(swaps, 1, "no swap");
		wr(CBT_ADDR_FLAGS, 8'h01);
		pulse(1);
		chk(swaps, 2, "swap");
		wr(CBT_ADDR_FLAGS, 8'h01);
		@(posedge aclk);
		sleep <= 1'b1;
		node.wake();
		sleep <= 1'b0;
		rchk(CBT_ADDR_FLAGS, 8'h80, "wake");
		chk({31'h0, irq_w}, 32'h1, "wake irq");
		wr(CBT_ADDR_ENABLES, 8'h7f);
		@(negedge aclk);
		chk({31'h0, irq_w}, 32'h0, "masked");
		wr(CBT_ADDR_CONTROL, 8'h01);
		pulse(0);
		rchk(CBT_ADDR_FLAGS, 8'h00, "soft reset");
		rd(8'h40);
		chk({30'h0, r}, {30'h0, CBT_AXI_SLVERR}, "unmapped");
		wr(8'h40, 8'h00);
		chk({30'h0, br}, {30'h0, CBT_AXI_SLVERR}, "wr unmapped");
		test_done();
	end
endmodule // tb
`default_nettype wire
